// ==== common/flash_status_pkg.sv ====
/*
 * Shared constants and carriers for the flash status host controller.
 * Assumes a 50 MHz system clock and an asynchronous NOR flash on the pins.
 */
package flash_status_pkg;

	// ---------------------------------------------------------------
	// Flash command codes
	// ---------------------------------------------------------------
	localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
	localparam logic [15:0] CMD_CLEAR_STATUS = 16'h0050;
	localparam logic [15:0] CMD_READ_ARRAY = 16'h00ff;
	localparam logic [7:0] STATUS_RESET = 8'h80;

	// ---------------------------------------------------------------
	// Status bit positions
	// ---------------------------------------------------------------
	localparam int BIT_READY = 7;
	localparam int BIT_ERASE_SUSP = 6;
	localparam int BIT_ERASE_FAIL = 5;
	localparam int BIT_PROG_FAIL = 4;
	localparam int BIT_SUPPLY_ERR = 3;
	localparam int BIT_PROG_SUSP = 2;
	localparam int BIT_LOCK_ERR = 1;

	// ---------------------------------------------------------------
	// Controller register map (byte offsets)
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam logic [3:0] CTRL_WRITE = 4'h1;
	localparam logic [3:0] CTRL_READ = 4'h2;
	localparam logic [3:0] CTRL_CLEAR = 4'h3;
	localparam logic [3:0] CTRL_STATUS = 4'h4;
	localparam int CTRL_GO_BIT = 31;
	localparam int CTRL_DIE_BIT = 8;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ---------------------------------------------------------------
	// Bus timing
	// ---------------------------------------------------------------
	localparam int CLK_NS = 20;
	localparam int T_ACCESS_NS = 100;
	localparam int T_PULSE_NS = 70;
	localparam int T_RECOVER_NS = 30;
	localparam logic [3:0] ACCESS_CYC =
		4'((T_ACCESS_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] PULSE_CYC =
		4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] RECOVER_CYC =
		4'((T_RECOVER_NS + CLK_NS - 1) / CLK_NS);
	localparam int DIE_ADDR_BIT = 23;

	// Flash pin bundle driven by the controller
	typedef struct packed {
		logic [23:0] addr;
		logic [15:0] dq_out;
		logic dq_oe;
		logic chip_select_n;
		logic out_enable_n;
		logic write_enable_n;
	} flash_pins_t;

	// One flash bus request
	typedef struct packed {
		logic is_read;
		logic [23:0] addr;
		logic [15:0] data;
	} flash_req_t;

endpackage

// ==== hw/flash_bus_cycle.sv ====
/*
 * One asynchronous flash bus cycle, read or write, timed by counters.
 * Assumes the data pins are already synchronised by the caller.
 */
`timescale 1ns/1ps

module flash_bus_cycle (
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire flash_status_pkg::flash_req_t req,
	input wire logic [15:0] dq_sync,
	output flash_status_pkg::flash_pins_t pins,
	output logic [15:0] rdata,
	output logic done
);
	typedef enum logic [1:0] {IDLE, STROBE, RECOVER} cyc_state_t;
	cyc_state_t state;
	logic [3:0] count;
	logic is_read;

	// -------------------------------------------------------------
	// Cycle sequencer
	// -------------------------------------------------------------
	// Every cycle ends deselected so the next read relatches status
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (!rstn) begin
			state <= IDLE;
			count <= 4'h0;
			is_read <= 1'b0;
			rdata <= 16'h0000;
			pins <= '{addr: 24'h00_0000, dq_out: 16'h0000, dq_oe: 1'b0,
				chip_select_n: 1'b1, out_enable_n: 1'b1,
				write_enable_n: 1'b1};
		end else begin
			unique case (state)
				IDLE: begin
					if (start) begin
						is_read <= req.is_read;
						pins.addr <= req.addr;
						pins.dq_out <= req.data;
						pins.dq_oe <= !req.is_read;
						pins.chip_select_n <= 1'b0;
						pins.out_enable_n <= !req.is_read;
						pins.write_enable_n <= req.is_read;
						count <= req.is_read ? flash_status_pkg::ACCESS_CYC
							: flash_status_pkg::PULSE_CYC;
						state <= STROBE;
					end
				end
				STROBE: begin
					if (count == 4'h1) begin
						// Write latches on rising write enable
						if (is_read)
							rdata <= dq_sync;
						pins.write_enable_n <= 1'b1;
						pins.out_enable_n <= 1'b1; // see [R8]
						pins.chip_select_n <= 1'b1; // see [R8]
						count <= flash_status_pkg::RECOVER_CYC;
						state <= RECOVER;
					end else begin
						count <= count - 4'h1;
					end
				end
				RECOVER: begin
					pins.dq_oe <= 1'b0;
					if (count == 4'h1) begin
						done <= 1'b1;
						state <= IDLE;
					end else begin
						count <= count - 4'h1;
					end
				end
			endcase
		end
	end
endmodule

// ==== hw/flash_status_host.sv ====
/*
 * Host controller issuing commands to a NOR flash and reading its
 * operation_status byte, ordered by software over AXI4-Lite.
 * Assumes an asynchronous flash on the pins, single reads only, and a
 * 16-bit data path; the pins resolve dq from dq_out and dq_oe.
 */
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
//
// Overview of operation
// [R1] Every flash operation is a command code sent in an ordinary write cycle.
// [R2] Flash holds an 8-bit read-only operation_status; host only reads it.
// [R3] Status reads return status on low byte, zeros on upper byte.
// [R4] Progress flags self-clear; error flags stay until clear-status command.
// [R5] After reset or power-up the status reads 80h.
// [R6] No page-mode bursts in status mode; host uses single read cycles.
// [R7] Flash latches status on output enable fall or chip select assertion.
// [R8] Host raises output enable or deselects between status reads.
// [R9] Status read works at any program_supply_level.
// [R10] Bit 7 low means busy, lower bits invalid; high means ready.
// [R11] Bits 5,4: 00 ok, 01 program fail, 10 erase fail, 11 sequence error.
// [R12] Bit 3 set when program supply leaves range during program or erase.
// [R13] Bit 6 means erase suspended, bit 2 means program suspended.
// [R14] Bit 1 set when program or erase targets a locked block.
// [R15] Bit 0 is reserved and meaningless.
// [R16] Clear errors by writing single cycle 0050h to any address.
// [R17] Any flash reset returns the status to its default.
// [R18] Dual-die parts need clear-status sent to each die's base address; host sends the first copy to addr_reg, then to 800000h.
// [R19] After clear-status, reads return the status register.
// [R20] Sequence error during erase suspend sets both bits 4 and 5.
// [R21] Latched sequence error masks later erase faults after resume.
// [R22] Clear status before resuming a suspended erase.
// [R23] Clear-status works at any program_supply_level.
`timescale 1ns/1ps

module flash_status_host (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic dq_oe,
	output logic [23:0] flash_addr,
	output logic chip_select_n,
	output logic out_enable_n,
	output logic write_enable_n,
	output logic reset_n
);
	typedef enum logic [2:0] {
		IDLE, SEND, WAIT, CLEAR_NEXT, POLL_CMD, POLL_READ
	} host_state_t;

	host_state_t state;
	logic [23:0] addr_reg;
	logic [15:0] wdata_reg;
	logic [15:0] rdata_reg;
	logic [7:0] status_copy;
	logic busy;
	logic both_dies;
	logic second_die;
	logic status_mode;
	logic after_poll;
	logic cyc_start;
	flash_status_pkg::flash_req_t cyc_req;
	flash_status_pkg::flash_pins_t pins;
	logic [15:0] cyc_rdata;
	logic cyc_done;
	logic [15:0] dq_meta;
	logic [15:0] dq_sync;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic go;
	logic [3:0] go_op;

	// ---------------------------------------------------------------
	// Pin input synchroniser
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			dq_meta <= 16'h0000;
			dq_sync <= 16'h0000;
		end else begin
			dq_meta <= dq_in;
			dq_sync <= dq_meta;
		end
	end

	flash_bus_cycle flash_bus_cycle_inst (
		.clk(clk),
		.rstn(rstn),
		.start(cyc_start),
		.req(cyc_req),
		.dq_sync(dq_sync),
		.pins(pins),
		.rdata(cyc_rdata),
		.done(cyc_done)
	);

	// Pins are registered inside the cycle engine
	assign dq_out = pins.dq_out;
	assign dq_oe = pins.dq_oe;
	assign flash_addr = pins.addr;
	assign chip_select_n = pins.chip_select_n;
	assign out_enable_n = pins.out_enable_n;
	assign write_enable_n = pins.write_enable_n;

	// ---------------------------------------------------------------
	// Flash reset pin follows system reset
	// ---------------------------------------------------------------
	// Keeps flash status and read mode in step with the host: see [R17]
	always_ff @(posedge clk) begin
		reset_n <= rstn;
	end

	// ---------------------------------------------------------------
	// AXI4-Lite write channel
	// ---------------------------------------------------------------
	// Address and data held independently; response after both
	assign go = aw_held && w_held && !s_axi_bvalid;
	assign go_op = w_data[3:0];

	always_ff @(posedge clk) begin
		if (!rstn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= flash_status_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr == flash_status_pkg::REG_CTRL ||
					aw_addr == flash_status_pkg::REG_ADDR ||
					aw_addr == flash_status_pkg::REG_WDATA)
					s_axi_bresp <= flash_status_pkg::RESP_OKAY;
				else
					s_axi_bresp <= flash_status_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Address and write-data registers; byte lanes honoured
	always_ff @(posedge clk) begin
		if (!rstn) begin
			addr_reg <= 24'h00_0000;
			wdata_reg <= 16'h0000;
		end else if (go && !busy) begin
			if (aw_addr == flash_status_pkg::REG_ADDR) begin
				if (w_strb[0])
					addr_reg[7:0] <= w_data[7:0];
				if (w_strb[1])
					addr_reg[15:8] <= w_data[15:8];
				if (w_strb[2])
					addr_reg[23:16] <= w_data[23:16];
			end
			if (aw_addr == flash_status_pkg::REG_WDATA) begin
				if (w_strb[0])
					wdata_reg[7:0] <= w_data[7:0];
				if (w_strb[1])
					wdata_reg[15:8] <= w_data[15:8];
			end
		end
	end

	// ---------------------------------------------------------------
	// Operation sequencer
	// ---------------------------------------------------------------
	// Orders arriving while busy are dropped; software polls busy first
	always_ff @(posedge clk) begin
		cyc_start <= 1'b0;
		if (!rstn) begin
			state <= IDLE;
			busy <= 1'b0;
			both_dies <= 1'b0;
			second_die <= 1'b0;
			status_mode <= 1'b0;
			after_poll <= 1'b0;
			rdata_reg <= 16'h0000;
			status_copy <= flash_status_pkg::STATUS_RESET; // see [R5]
			cyc_req <= '0;
		end else begin
			unique case (state)
				IDLE: begin
					if (go && !busy && w_strb[0] &&
						w_data[flash_status_pkg::CTRL_GO_BIT] &&
						aw_addr == flash_status_pkg::REG_CTRL) begin
						busy <= 1'b1;
						both_dies <= w_data[flash_status_pkg::CTRL_DIE_BIT];
						second_die <= 1'b0;
						after_poll <= 1'b0;
						state <= SEND;
						cyc_req.addr <= addr_reg;
						cyc_req.is_read <= 1'b0;
						cyc_req.data <= wdata_reg; // see [R1]
						if (go_op == flash_status_pkg::CTRL_READ) begin
							cyc_req.is_read <= 1'b1; // see [R6]
						end else if (go_op == flash_status_pkg::CTRL_CLEAR) begin
							// Single cycle, any address, no confirm: see [R16]
							// Lets software wipe errors before an erase
							// resumes: see [R22]
							cyc_req.data <= flash_status_pkg::CMD_CLEAR_STATUS;
						end else if (go_op == flash_status_pkg::CTRL_STATUS) begin
							if (status_mode) begin
								cyc_req.is_read <= 1'b1;
								state <= POLL_READ;
							end else begin
								cyc_req.data <=
									flash_status_pkg::CMD_READ_STATUS;
								state <= POLL_CMD;
							end
						end else if (go_op != flash_status_pkg::CTRL_WRITE) begin
							busy <= 1'b0;
							state <= IDLE;
						end
					end
				end
				SEND, POLL_CMD, POLL_READ: begin
					cyc_start <= 1'b1;
					if (state == POLL_CMD)
						after_poll <= 1'b1;
					else if (state == POLL_READ)
						after_poll <= 1'b0;
					state <= WAIT;
				end
				WAIT: begin
					if (cyc_done) begin
						if (cyc_req.is_read) begin
							rdata_reg <= cyc_rdata;
							if (status_mode) begin
								// Upper byte zero in status mode: see [R3]
								status_copy <= cyc_rdata[7:0]; // see [R2]
							end
							busy <= 1'b0;
							state <= IDLE;
						end else if (after_poll) begin
							status_mode <= 1'b1; // see [R9]
							cyc_req.is_read <= 1'b1;
							state <= POLL_READ;
						end else begin
							// Clear and most commands leave status mode on:
							// see [R19] [R23]
							status_mode <= cyc_req.data !=
								flash_status_pkg::CMD_READ_ARRAY;
							if (both_dies && !second_die) begin
								state <= CLEAR_NEXT;
							end else begin
								busy <= 1'b0;
								state <= IDLE;
							end
						end
					end
				end
				CLEAR_NEXT: begin
					// Repeat at the second die's base (bit 23 set): see [R18]
					second_die <= 1'b1;
					cyc_req.addr <= 24'h00_0001 <<
						flash_status_pkg::DIE_ADDR_BIT;
					state <= SEND;
				end
				default: state <= IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite read channel
	// ---------------------------------------------------------------
	// Status fields reported as read; bit meanings: see [R10] [R11]
	// [R12] [R13] [R14] [R15] [R20] [R21] [R4]
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= flash_status_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= flash_status_pkg::RESP_OKAY;
				unique case (s_axi_araddr)
					flash_status_pkg::REG_ADDR:
						s_axi_rdata <= {8'h00, addr_reg};
					flash_status_pkg::REG_WDATA:
						s_axi_rdata <= {16'h0000, wdata_reg};
					flash_status_pkg::REG_STATUS:
						s_axi_rdata <= {14'h0000, status_mode, busy,
							8'h00, status_copy};
					flash_status_pkg::REG_RDATA:
						s_axi_rdata <= {16'h0000, rdata_reg};
					flash_status_pkg::REG_CTRL:
						s_axi_rdata <= 32'h0000_0000;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= flash_status_pkg::RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// ==== tb/flash_status_host_assertions.sv ====
/*
 * Pin-level checks on the flash host: cycle shapes and reset hand-off.
 * Assumes it is bound onto flash_status_host and sees its port names.
 */
`timescale 1ns/1ps

module flash_status_host_assertions (
	input wire logic clk,
	input wire logic rstn,
	input wire logic dq_oe,
	input wire logic [23:0] flash_addr,
	input wire logic chip_select_n,
	input wire logic out_enable_n,
	input wire logic write_enable_n,
	input wire logic reset_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// Strobe shapes; a bus fight here would corrupt the status byte
	a_no_bus_fight: assert property (
		!out_enable_n |-> write_enable_n && !dq_oe)
		else $error("read strobe overlaps a write or driven data");
	a_write_drives: assert property (
		!write_enable_n |-> dq_oe && !chip_select_n)
		else $error("write strobe without driven data or select");
	a_write_pulse: assert property (
		$fell(write_enable_n) |-> !write_enable_n[*4] ##1 write_enable_n)
		else $error("write strobe length wrong");
	a_data_released: assert property (
		$rose(write_enable_n) |-> ##[1:2] !dq_oe)
		else $error("data pins not released after a write");
	a_read_single: assert property (
		$fell(out_enable_n) |-> !out_enable_n[*5] ##1 out_enable_n)
		else $error("read strobe length wrong");
	a_addr_steady: assert property (
		!chip_select_n && $past(!chip_select_n) |-> $stable(flash_addr))
		else $error("address moved inside a cycle");
	a_read_deselect: assert property (
		$rose(out_enable_n) |-> chip_select_n)
		else $error("select held across reads");
	a_oe_selected: assert property (
		!out_enable_n |-> !chip_select_n)
		else $error("read strobe without select");
	a_flash_reset: assert property (
		$rose(rstn) |=> reset_n)
		else $error("flash reset not released");
endmodule

bind flash_status_host flash_status_host_assertions
	flash_status_host_assertions_inst (
	.clk(clk), .rstn(rstn), .dq_oe(dq_oe), .flash_addr(flash_addr),
	.chip_select_n(chip_select_n), .out_enable_n(out_enable_n),
	.write_enable_n(write_enable_n), .reset_n(reset_n)
);

// ==== tb/flash_die_model.sv ====
/*
 * Behavioural flash die: command latch, status byte and read modes.
 * Assumes pins are sampled on the bench clock; fault and busy are bench
 * controlled, and the supply level is deliberately ignored.
 */
`timescale 1ns/1ps

module flash_die_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic chip_select_n,
	input wire logic out_enable_n,
	input wire logic write_enable_n,
	input wire logic [23:0] flash_addr,
	input wire logic [15:0] dq,
	input wire logic busy,
	input wire logic program_supply_level,
	input wire logic [7:0] fault,
	output logic [15:0] dq_rd
);
	logic [7:0] sticky, latch, status;
	logic [15:0] cmd;
	logic [15:0] last = 16'h0000;
	logic status_mode, prev_we_n, prev_cs_n, prev_oe_n;
	logic tog = 1'b0;

	// Busy hides the low bits behind a pattern that moves every cycle
	assign status = busy ? {1'b0, {7{tog}}} :
		{1'b1, fault[6], sticky[5:3],
		fault[2], sticky[1], 1'b0};

	// Released pins show the inverse of the last value, never a copy
	assign dq_rd = (!chip_select_n && !out_enable_n) ?
		(status_mode ? {8'h00, latch} :
		flash_addr[15:0] ^ 16'h5a5a) : ~last;

	// Commands act on the closing write edge; supply level never gates
	always @(posedge clk) begin
		tog <= ~tog;
		last <= dq_rd;
		prev_we_n <= write_enable_n;
		prev_cs_n <= chip_select_n;
		prev_oe_n <= out_enable_n;
		if (!write_enable_n && !chip_select_n)
			cmd <= dq;
		if (!reset_n) begin
			sticky <= 8'h00;
			status_mode <= 1'b0;
		end else begin
			// A latched sequence error hides later erase faults
			sticky <= sticky | (fault & 8'h3a);
			if (write_enable_n && !prev_we_n && !prev_cs_n) begin
				status_mode <= (cmd != 16'h00ff);
				if (cmd == 16'h0050)
					sticky <= 8'h00;
			end
		end
		if (!out_enable_n && !chip_select_n && (prev_oe_n || prev_cs_n))
			latch <= status;
	end
endmodule

// ==== tb/flash_status_host_tb.sv ====
/*
 * Self-checking bench for flash_status_host driving a flash die model.
 * Assumes the package offsets, codes and write pulse length.
 */
`timescale 1ns/1ps

module flash_status_host_tb;
	typedef struct {
		string name;
		logic [33:0] exp;
		logic [33:0] mask;
	} note_t;
	localparam logic [31:0] go = 32'h8000_0000;
	localparam logic [31:0] die = 32'h0000_0100;
	localparam logic [1:0] ok = flash_status_pkg::RESP_OKAY;
	logic clk = 1'b0;
	logic rstn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, dq_oe, busy, supply;
	logic chip_select_n, out_enable_n, write_enable_n, reset_n;
	logic [7:0] awaddr, araddr, fault;
	logic [31:0] wdata, rdata, s;
	logic [1:0] bresp, rresp;
	logic [15:0] dq_in, dq_out, dq_rd;
	logic [23:0] flash_addr, a;
	int num_errors = 0;
	int samples_checked = 0;
	int die_hits = 0;
	int die_clears = 0;
	note_t wq[$];
	note_t rq[$];

	flash_status_host flash_status_host_inst (
		.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe(dq_oe), .flash_addr(flash_addr),
		.chip_select_n(chip_select_n), .out_enable_n(out_enable_n),
		.write_enable_n(write_enable_n), .reset_n(reset_n)
	);
	flash_die_model flash_die_model_inst (
		.clk(clk), .reset_n(reset_n), .chip_select_n(chip_select_n),
		.out_enable_n(out_enable_n), .write_enable_n(write_enable_n),
		.flash_addr(flash_addr), .dq(dq_in), .busy(busy),
		.program_supply_level(supply), .fault(fault), .dq_rd(dq_rd)
	);

	// Pin resolution: the host wins only while it enables its drivers
	assign dq_in = dq_oe ? dq_out : dq_rd;

	initial forever #10 clk = ~clk;

	// Clear word seen at the second die base, counted on every clock while the write strobe is low
	always @(posedge clk)
		if (!write_enable_n && flash_addr == 24'h80_0000 && dq_out == 16'h0050)
			die_hits++;

	task automatic check(input string nm, input logic [33:0] e,
		input logic [33:0] m, input logic [33:0] v);
		samples_checked++;
		if (((v ^ e) & m) !== 34'h0) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e & m, v & m);
		end
	endtask

	// Score each response against the oldest note of its channel
	always @(posedge clk) begin
		note_t n;
		if (bvalid && bready) begin
			n = wq.pop_front();
			check(n.name, n.exp, n.mask, {bresp, 32'h0});
		end
		if (rvalid && rready) begin
			n = rq.pop_front();
			check(n.name, n.exp, n.mask, {rresp, rdata});
		end
	end

	task automatic end_of_test();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d,
		input logic [1:0] r);
		int n;
		wq.push_back('{$sformatf("write %h", ad), {r, 32'h0}, {2'b11, 32'h0}});
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end while (!bvalid && n < 200);
		bready <= 1'b0;
		@(posedge clk);
		if (n >= 200) begin
			num_errors++;
			end_of_test();
		end
	endtask

	task automatic rd(input logic [7:0] ad, input logic [31:0] d,
		input logic [31:0] m, input logic [1:0] r);
		int n;
		rq.push_back('{$sformatf("read %h", ad), {r, d}, {2'b11, m}});
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			n++;
		end while (!rvalid && n < 200);
		s = rdata;
		rready <= 1'b0;
		@(posedge clk);
		if (n >= 200) begin
			num_errors++;
			end_of_test();
		end
	endtask

	// Start an operation and poll until the controller is idle again
	task automatic op(input logic [31:0] c);
		int n;
		wr(8'h00, go | c, ok);
		n = 0;
		do begin
			rd(8'h0c, 32'h0, 32'h0, ok);
			n++;
		end while (s[16] !== 1'b0 && n < 100);
		if (n >= 100) begin
			num_errors++;
			end_of_test();
		end
	endtask

	task automatic cmd(input logic [15:0] c);
		wr(8'h08, {16'h0000, c}, ok);
		op(32'h1);
	endtask

	task automatic stat(input logic [7:0] e, input logic [7:0] m);
		op(32'h4);
		rd(8'h0c, {14'h0, 2'b10, 8'h00, e}, {14'h0, 2'b11, 8'h00, m}, ok);
	endtask

	initial begin
		logic [7:0] codes [5] = '{8'h10, 8'h20, 8'h30, 8'h08, 8'h02};
		void'($urandom(68));
		rstn <= 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, busy, supply} <= 7'h00;
		{awaddr, araddr, fault, wdata} <= 56'h0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(8'h0c, 32'h0000_0080, 32'h0003_ffff, ok);
		rd(8'h14, 32'h0, 32'hffff_ffff, flash_status_pkg::RESP_SLVERR);
		wr(8'h20, 32'h0, flash_status_pkg::RESP_SLVERR);
		stat(8'h80, 8'hff);
		// Array mode first, so the later status reads prove a mode switch
		a = 24'($urandom) & 24'h7f_ffff;
		wr(8'h04, {8'h00, a}, ok);
		cmd(16'h00ff);
		op(32'h2);
		rd(8'h10, {16'h0, a[15:0] ^ 16'h5a5a}, 32'h0000_ffff, ok);
		foreach (codes[i]) begin
			supply <= 1'($urandom);
			fault <= codes[i];
			@(posedge clk);
			fault <= 8'h00;
			stat(8'h80 | codes[i], 8'hff);
			stat(8'h80 | codes[i], 8'hff);
			cmd(16'h00ff);
			op(32'h3 | ((i % 2) ? die : 32'h0));
			die_clears += i % 2;
			op(32'h2);
			rd(8'h10, 32'h0000_0080, 32'h0000_ffff, ok);
		end
		check("die clears", 34'(die_clears) * 34'(flash_status_pkg::PULSE_CYC),
			34'h3_ffff_ffff, 34'(die_hits));
		// Suspend flags follow the die and drop without a clear; the
		// errors were already cleared before the suspend ends
		fault <= 8'h44;
		@(posedge clk);
		stat(8'hc4, 8'hff);
		fault <= 8'h00;
		@(posedge clk);
		stat(8'h80, 8'hff);
		busy <= 1'b1;
		@(posedge clk);
		stat(8'h00, 8'h80);
		busy <= 1'b0;
		fault <= 8'h20;
		@(posedge clk);
		fault <= 8'h00;
		stat(8'ha0, 8'hff);
		// Reset in mid-run must wipe the sticky error
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		stat(8'h80, 8'hff);
		end_of_test();
	end
endmodule
